// >>> design/edge_counter_regs.svh
// Register offsets, field positions and reset values of the edge counter
`ifndef EDGE_COUNTER_REGS_SVH
`define EDGE_COUNTER_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_GATE 5'h00
`define OFS_CTRL 5'h04
`define OFS_TRIG 5'h08
`define OFS_RELOAD 5'h0c
`define OFS_COUNT 5'h10
`define OFS_STATUS 5'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_W 7
`define TRIG_START_BIT 0
`define TRIG_STOP_BIT 1
`define STAT_ACTIVE_BIT 0
`define STAT_OUT_BIT 1
`define STAT_WAIT_BIT 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GATE_RST 1'b0
`define CTRL_RST 7'h00

`endif

// >>> design/edge_counter_pkg.sv
// Types shared by the edge counter and divider channel
`default_nettype none

package edge_counter_pkg;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10
  } edge_sel_t;

  typedef enum logic {
    MODE_EVENT = 1'b0,
    MODE_DIVIDE = 1'b1
  } chan_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_COUNT = 2'b10
  } chan_state_t;

  // Channel control word, 7 bits
  typedef struct packed {
    logic filter_en;
    logic out_en;
    logic out_level;
    logic start_int_sel;
    edge_sel_t edge_sel;
    chan_mode_t mode;
  } chan_ctrl_t;

endpackage : edge_counter_pkg

`default_nettype wire

// >>> design/edge_event_counter_divider.sv
// Event counter and frequency divider channel with its register port
`include "edge_counter_regs.svh"
`default_nettype none

module edge_event_counter_divider #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [4:0] addr,
  input wire logic [CNT_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [CNT_W-1:0] rdata,
  // Event or divider input pin
  input wire logic event_input_pin,
  // Output pin
  output logic channel_output_pin,
  output logic channel_output_oe,
  // Channel event
  output logic channel_interrupt
);

  // --------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------
  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 8 and 32");
  end

  // --------------------------------------------------------------------
  // Input synchroniser, filter and edge detector
  // --------------------------------------------------------------------
  logic sync1_reg, sync2_reg, samp_reg, lvl_reg, edge_reg;
  logic sync1_next, sync2_next, samp_next, lvl_next, edge_next;
  logic unit_clock_gate;
  edge_counter_pkg::chan_ctrl_t ctrl_reg, ctrl_next;

  always_comb begin
    sync1_next = event_input_pin;
    sync2_next = sync1_reg;
    samp_next = sync2_reg;
    if (ctrl_reg.filter_en && sync2_reg != samp_reg) begin
      lvl_next = lvl_reg;
    end else begin
      lvl_next = sync2_reg;
    end
    unique case (ctrl_reg.edge_sel)
      edge_counter_pkg::EDGE_RISE: edge_next = lvl_next & ~lvl_reg;
      edge_counter_pkg::EDGE_FALL: edge_next = ~lvl_next & lvl_reg;
      edge_counter_pkg::EDGE_BOTH: edge_next = lvl_next ^ lvl_reg;
      default: edge_next = 1'b0;
    endcase
    if (!unit_clock_gate) begin
      edge_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      samp_reg <= 1'b0;
      lvl_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      samp_reg <= samp_next;
      lvl_reg <= lvl_next;
      edge_reg <= edge_next;
    end
  end

  // --------------------------------------------------------------------
  // Channel registers and counter
  // --------------------------------------------------------------------
  logic gate_reg, gate_next;
  logic [CNT_W-1:0] reload_reg, reload_next, count_reg, count_next;
  logic out_reg, out_next, irq_reg, irq_next;
  edge_counter_pkg::chan_state_t state_reg, state_next;
  logic wr_ok, start_wr, stop_wr, active;

  assign unit_clock_gate = gate_reg;
  assign wr_ok = wr && gate_reg;
  assign start_wr = wr_ok && addr == `OFS_TRIG && wdata[`TRIG_START_BIT];
  assign stop_wr = wr_ok && addr == `OFS_TRIG && wdata[`TRIG_STOP_BIT];
  assign active = state_reg != edge_counter_pkg::ST_IDLE;

  always_comb begin
    gate_next = gate_reg;
    ctrl_next = ctrl_reg;
    reload_next = reload_reg;
    count_next = count_reg;
    out_next = out_reg;
    state_next = state_reg;
    irq_next = 1'b0;
    if (wr && addr == `OFS_GATE) begin
      gate_next = wdata[0];
    end
    if (wr_ok && addr == `OFS_CTRL) begin
      ctrl_next = edge_counter_pkg::chan_ctrl_t'(wdata[`CTRL_W-1:0]);
    end
    if (wr_ok && addr == `OFS_RELOAD) begin
      reload_next = wdata;
    end
    if (!active) begin
      out_next = ctrl_reg.out_level;
    end
    unique case (state_reg)
      edge_counter_pkg::ST_IDLE: begin
      end
      edge_counter_pkg::ST_WAIT: begin
        if (edge_reg) begin
          count_next = reload_reg;
          state_next = edge_counter_pkg::ST_COUNT;
          if (ctrl_reg.start_int_sel) begin
            irq_next = 1'b1;
            out_next = ~out_reg;
          end
        end
      end
      edge_counter_pkg::ST_COUNT: begin
        if (edge_reg) begin
          if (count_reg == '0) begin
            count_next = reload_reg;
            irq_next = 1'b1;
            out_next = ~out_reg;
          end else begin
            count_next = count_reg - 1'b1;
          end
        end
      end
      default: state_next = edge_counter_pkg::ST_IDLE;
    endcase
    if (start_wr) begin
      if (ctrl_reg.mode == edge_counter_pkg::MODE_EVENT) begin
        count_next = reload_reg;
        state_next = edge_counter_pkg::ST_COUNT;
      end else begin
        state_next = edge_counter_pkg::ST_WAIT;
      end
      irq_next = 1'b0;
    end
    if (stop_wr) begin
      state_next = edge_counter_pkg::ST_IDLE;
      count_next = count_reg;
      irq_next = 1'b0;
    end
    if (!gate_reg) begin
      ctrl_next = `CTRL_RST;
      reload_next = '0;
      count_next = '0;
      out_next = 1'b0;
      state_next = edge_counter_pkg::ST_IDLE;
      irq_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_reg <= `GATE_RST;
      ctrl_reg <= `CTRL_RST;
      reload_reg <= '0;
      count_reg <= '0;
      out_reg <= 1'b0;
      state_reg <= edge_counter_pkg::ST_IDLE;
      irq_reg <= 1'b0;
    end else begin
      gate_reg <= gate_next;
      ctrl_reg <= ctrl_next;
      reload_reg <= reload_next;
      count_reg <= count_next;
      out_reg <= out_next;
      state_reg <= state_next;
      irq_reg <= irq_next;
    end
  end

  assign channel_output_pin = out_reg;
  assign channel_output_oe = ctrl_reg.out_en;
  assign channel_interrupt = irq_reg;

  // --------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------
  logic [CNT_W-1:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = '0;
    if (rd) begin
      unique case (addr)
        `OFS_GATE: rdata_next[0] = gate_reg;
        `OFS_CTRL: rdata_next[`CTRL_W-1:0] = ctrl_reg;
        `OFS_TRIG: rdata_next = '0;
        `OFS_RELOAD: rdata_next = reload_reg;
        `OFS_COUNT: rdata_next = count_reg;
        `OFS_STATUS: begin
          rdata_next[`STAT_ACTIVE_BIT] = active;
          rdata_next[`STAT_OUT_BIT] = out_reg;
          rdata_next[`STAT_WAIT_BIT] =
            state_reg == edge_counter_pkg::ST_WAIT;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  wire cnt_edge = edge_reg && state_reg == edge_counter_pkg::ST_COUNT
    && gate_reg && !start_wr && !stop_wr;

  zero_interrupt_a: assert property (
    cnt_edge && count_reg == '0 |=> channel_interrupt
      && count_reg == $past(reload_reg))
    else $error("No reload and interrupt at zero");

  down_count_a: assert property (
    cnt_edge && count_reg != '0 |=> !channel_interrupt
      && count_reg == $past(count_reg) - 1'b1)
    else $error("Counter did not decrement on edge");

  start_load_a: assert property (
    start_wr && !stop_wr && ctrl_reg.mode == edge_counter_pkg::MODE_EVENT
      |=> active && count_reg == $past(reload_reg))
    else $error("Start did not load reload value");

  stop_hold_a: assert property (
    stop_wr |=> !active && count_reg == $past(count_reg))
    else $error("Stop did not halt with count held");

  gate_off_init_a: assert property (
    !gate_reg && !(wr && addr == `OFS_GATE) |=> count_reg == '0
      && !active && reload_reg == '0)
    else $error("Gate off did not initialise channel");

  trigger_reads_zero_a: assert property (
    rd && addr == `OFS_TRIG |=> rdata == '0)
    else $error("Trigger register did not read zero");

  count_read_a: assert property (
    rd && addr == `OFS_COUNT |=> rdata == $past(count_reg))
    else $error("Count readback mismatch");

  edge_pulse_a: assert property (
    edge_reg |-> lvl_reg != $past(lvl_reg))
    else $error("Edge pulse without level change");

  divider_toggle_a: assert property (
    cnt_edge && count_reg == '0 |=> channel_output_pin
      != $past(channel_output_pin))
    else $error("Output did not toggle at zero");

  first_edge_a: assert property (
    state_reg == edge_counter_pkg::ST_WAIT && edge_reg && gate_reg
      && !start_wr && !stop_wr && !ctrl_reg.start_int_sel
      |=> count_reg == $past(reload_reg) && !channel_interrupt
      && channel_output_pin == $past(channel_output_pin))
    else $error("First divider edge mishandled");

  reload_defer_a: assert property (
    wr_ok && addr == `OFS_RELOAD && active && !edge_reg && !start_wr
      |=> count_reg == $past(count_reg))
    else $error("Reload write disturbed running count");

  count_hold_a: assert property (
    active && !edge_reg && !start_wr && !stop_wr && gate_reg
      |=> count_reg == $past(count_reg))
    else $error("Count moved without an input edge");

  irq_cause_a: assert property (
    channel_interrupt |-> $past(edge_reg) && $past(active))
    else $error("Interrupt without a counted edge");

  divider_wait_a: assert property (
    start_wr && !stop_wr && ctrl_reg.mode == edge_counter_pkg::MODE_DIVIDE
      |=> state_reg == edge_counter_pkg::ST_WAIT && !channel_interrupt)
    else $error("Divider start did not wait for first edge");

  first_edge_int_a: assert property (
    state_reg == edge_counter_pkg::ST_WAIT && edge_reg && gate_reg
      && !start_wr && !stop_wr && ctrl_reg.start_int_sel
      |=> count_reg == $past(reload_reg) && channel_interrupt
      && channel_output_pin != $past(channel_output_pin))
    else $error("First divider edge gave no interrupt and toggle");

  rdata_idle_a: assert property (
    !rd |=> rdata == '0)
    else $error("Read data not zero outside read cycle");

  event_no_wait_a: assert property (
    state_reg == edge_counter_pkg::ST_WAIT
      |-> ctrl_reg.mode == edge_counter_pkg::MODE_DIVIDE)
    else $error("Event mode entered first edge wait");

  cover_event_irq_c: cover property (
    ctrl_reg.mode == edge_counter_pkg::MODE_EVENT && channel_interrupt);
  cover_divider_toggle_c: cover property (
    ctrl_reg.mode == edge_counter_pkg::MODE_DIVIDE && cnt_edge
      && count_reg == '0);
  cover_stop_c: cover property (active ##1 stop_wr);
  cover_gate_off_c: cover property (active ##1 !gate_reg);
  cover_first_int_c: cover property (
    state_reg == edge_counter_pkg::ST_WAIT && edge_reg
      && ctrl_reg.start_int_sel);

endmodule : edge_event_counter_divider

`default_nettype wire

// >>> sim/edge_source.sv
// Edge source that toggles the channel input pin in bursts
`default_nettype none

module edge_source (
  // Clock and burst request
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_tog,
  input wire logic [3:0] half,
  // Driven pin and burst state
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pin_q = 1'b0;
  logic busy_q = 1'b0;
  logic [7:0] left = 8'h00;
  logic [3:0] tick = 4'h0;

  assign pin = pin_q;
  assign busy = busy_q;

  always @(posedge clk) begin
    if (busy_q == 1'b0) begin
      if (go && n_tog != 8'h00) begin
        busy_q <= 1'b1;
        left <= n_tog;
        tick <= half;
      end
    end else if (tick > 4'h1) begin
      tick <= tick - 4'h1;
    end else begin
      // Each level stands for half cycles, three or more
      pin_q <= !pin_q;
      tick <= half;
      left <= left - 8'h01;
      busy_q <= (left != 8'h01);
    end
  end
endmodule : edge_source

`default_nettype wire

// >>> sim/edge_event_counter_divider_tb.sv
// Self-checking bench for the edge counter and divider channel
`include "edge_counter_regs.svh"
`default_nettype none

module edge_event_counter_divider_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic out_q = 1'b0;
  logic busy, pin, out_pin, out_oe, irq;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, v;
  logic [7:0] n_tog = 8'h00;
  logic [3:0] half = 4'h3;
  logic [1:0] esel;
  int fail_count = 0;
  int n_compared = 0;
  int irq_seen = 0;
  int tog_seen = 0;
  int seed = 32'hde4f9453;
  int m_cnt, m_rel, m_irq, m_tog, m_act, m_wait, m_sel;
  edge_counter_pkg::chan_ctrl_t ctl;
  logic [1:0] sel_tbl [6] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2};

  always #2.5 clk = ~clk;

  edge_event_counter_divider i_edge_event_counter_divider (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .event_input_pin(pin),
    .channel_output_pin(out_pin), .channel_output_oe(out_oe),
    .channel_interrupt(irq));

  edge_source i_edge_source (.clk(clk), .go(go), .n_tog(n_tog),
    .half(half), .pin(pin), .busy(busy));

  always @(negedge clk) begin
    if (irq === 1'b1) irq_seen++;
    if (out_pin !== out_q) tog_seen++;
    out_q <= out_pin;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  // Reference model: one valid edge
  task automatic step();
    if (m_act == 0) return;
    if (m_wait != 0) begin
      m_wait = 0;
      m_cnt = m_rel;
      m_irq += m_sel;
      m_tog += m_sel;
    end else if (m_cnt == 0) begin
      m_cnt = m_rel;
      m_irq++;
      m_tog++;
    end else begin
      m_cnt--;
    end
  endtask : step

  task automatic burst(input int n);
    int k;
    logic lvl;
    lvl = pin;
    for (k = 0; k < n; k++) begin
      lvl = !lvl;
      if (esel == 2'h2 || (esel == 2'h1) == lvl) step();
    end
    @(posedge clk);
    n_tog <= 8'(n);
    half <= 4'(3 + ($random(seed) & 3));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 2000);
    if (k >= 2000) begin
      fail_count++;
      give_verdict();
    end
    repeat (8) @(negedge clk);
  endtask : burst

  task automatic check_all();
    rd_reg(`OFS_COUNT, v);
    chk("count", 16'(m_cnt), v);
    chk("interrupts", 16'(m_irq), 16'(irq_seen));
    chk("toggles", 16'(m_tog), 16'(tog_seen));
  endtask : check_all

  initial begin
    int i;
    m_irq = 0;
    m_tog = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(`OFS_GATE, v);
    chk("gate reset", 16'h0000, v);
    wr_reg(`OFS_CTRL, 16'h007f);
    rd_reg(`OFS_CTRL, v);
    chk("ctrl gated", 16'h0000, v);
    rd_reg(5'h1c, v);
    chk("unmapped", 16'h0000, v);
    wr_reg(`OFS_GATE, 16'h0001);
    wr_reg(`OFS_CTRL, 16'h0010);
    rd_reg(`OFS_STATUS, v);
    chk("idle level", 16'h0002, v);
    wr_reg(`OFS_CTRL, 16'h0000);
    m_tog += 2;
    for (i = 0; i < 6; i++) begin
      ctl = '0;
      ctl.mode = edge_counter_pkg::chan_mode_t'(i >= 2);
      esel = sel_tbl[i];
      ctl.edge_sel = edge_counter_pkg::edge_sel_t'(esel);
      ctl.start_int_sel = i[0];
      ctl.out_en = (i >= 2);
      ctl.filter_en = 1'($random(seed) & 1);
      m_rel = $random(seed) & 3;
      wr_reg(`OFS_RELOAD, 16'(m_rel));
      wr_reg(`OFS_CTRL, 16'(ctl));
      wr_reg(`OFS_TRIG, 16'h0001);
      m_act = 1;
      m_wait = (i >= 2);
      m_cnt = m_rel;
      m_sel = i & 1;
      rd_reg(`OFS_TRIG, v);
      chk("trigger", 16'h0000, v);
      rd_reg(`OFS_STATUS, v);
      chk("status", 16'({m_wait[0], m_tog[0], 1'b1}), v);
      chk("oe", 16'(ctl.out_en), 16'(out_oe));
      if (m_wait == 0) begin
        rd_reg(`OFS_COUNT, v);
        chk("start count", 16'(m_rel), v);
      end
      burst(9 + ($random(seed) & 7));
      check_all();
      m_rel = 4 + ($random(seed) & 3);
      wr_reg(`OFS_RELOAD, 16'(m_rel));
      check_all();
      burst(12 + ($random(seed) & 7));
      check_all();
      wr_reg(`OFS_TRIG, 16'h0002);
      m_act = 0;
      if (m_tog % 2 == 1) m_tog++;
      burst(4);
      check_all();
      rd_reg(`OFS_STATUS, v);
      chk("stopped", 16'h0000, 16'(v[0]));
    end
    wr_reg(`OFS_GATE, 16'h0000);
    rd_reg(`OFS_RELOAD, v);
    chk("reload cleared", 16'h0000, v);
    wr_reg(`OFS_RELOAD, 16'h0005);
    rd_reg(`OFS_RELOAD, v);
    chk("reload gated", 16'h0000, v);
    chk("pin cleared", 16'h0000, 16'(out_pin));
    give_verdict();
  end
endmodule : edge_event_counter_divider_tb

`default_nettype wire
